// file: ata_device_command_core.sv
// Device-side command core: task-file decode, identify transfer and flash upkeep.
`timescale 1ns/1ps
module ata_device_command_core
    import ata_core_pkg::*;
#(
    parameter logic [31:0] TOTAL_SECTORS = 32'h0000_0000,
    parameter int NUM_BLOCKS = 64,
    parameter int PAGES_PER_BLOCK = 64
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic dev_wr,
    input wire logic [7:0] dev_wdata,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic status_rd,
    input wire logic nien,
    input wire logic data_rd,
    output logic [15:0] data_word,
    output logic data_valid,
    output logic [7:0] status_ff,
    output logic [7:0] device_select_ff,
    output logic [7:0] error_ff,
    output logic [7:0] sector_count_ff,
    output logic intrq_ff,
    input wire logic fl_wr_valid,
    input wire logic [7:0] fl_wr_byte,
    input wire logic fl_rd_valid,
    input wire logic [7:0] fl_rd_byte,
    input wire logic [7:0] fl_rd_parity,
    input wire logic [3:0] fl_err_bits,
    input wire logic [$clog2(NUM_BLOCKS)-1:0] fl_rd_block,
    input wire logic sector_wr_req,
    output logic [7:0] parity_ff,
    output logic parity_valid_ff,
    output logic ecc_corr_ff,
    output logic [$clog2(NUM_BLOCKS)-1:0] reloc_src_ff,
    output logic [$clog2(NUM_BLOCKS)-1:0] reloc_dst_ff,
    output logic reloc_req_ff,
    output logic [$clog2(NUM_BLOCKS)-1:0] phys_block_ff,
    output logic [$clog2(PAGES_PER_BLOCK)-1:0] phys_page_ff
);
    localparam int BW = $clog2(NUM_BLOCKS);
    localparam int PW = $clog2(PAGES_PER_BLOCK);
    localparam int BAD_MAX = (NUM_BLOCKS * BAD_PERMILLE) / 1000;
    localparam int SECT_PER_PAGE = PAGE_BYTES / ECC_BLOCK_BYTES;
    localparam int BYTE_W = $clog2(ECC_BLOCK_BYTES);

    initial begin
        if (NUM_BLOCKS < 16 || PAGES_PER_BLOCK < 2) $error("Flash geometry too small.");
        if (SECT_PER_PAGE != 8) $error("Page must hold eight ECC blocks.");
    end

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_PREP = 4'b0010,
        S_XFER = 4'b0100,
        S_DRAIN = 4'b1000
    } cmd_state_e;

    cmd_state_e state_ff;
    logic [2:0] prep_cnt_ff;
    logic [8:0] word_idx_ff;
    logic [8:0] read_cnt_ff;
    logic [15:0] word_data_ff;
    logic word_valid_ff;
    logic [7:0] wr_lfsr_ff;
    logic [7:0] rd_lfsr_ff;
    logic [BYTE_W-1:0] wr_byte_cnt_ff;
    logic [BYTE_W-1:0] rd_byte_cnt_ff;
    logic [NUM_BLOCKS-1:0] bad_ff;
    logic [BW:0] bad_cnt_ff;
    logic [BW-1:0] spare_ff;
    logic [2:0] sect_in_page_ff;
    logic data_valid_w;
    logic [15:0] data_word_w;
    logic rd_block_end;
    logic [7:0] syndrome;
    logic word_taken;
    logic out_free;

    word_stream_if #(.WIDTH(16)) ident_s ();

    // Advance an 8-bit parity register by one byte, shared by both ECC paths.
    function automatic logic [7:0] lfsr_step(input logic [7:0] cur, input logic [7:0] din);
        logic [7:0] r;
        r = cur;
        for (int i = 7; i >= 0; i--) begin
            r = (r[7] ^ din[i]) ? ((r << 1) ^ ECC_POLY) : (r << 1);
        end
        lfsr_step = r;
    endfunction

    // Next block to place data in, skipping blocks already flagged bad.
    function automatic logic [BW-1:0] next_good(input logic [BW-1:0] cur,
                                                input logic [NUM_BLOCKS-1:0] bad);
        logic [BW-1:0] n;
        n = cur;
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            n = BW'(n + 1'b1);
            if (!bad[n]) break;
        end
        next_good = n;
    endfunction

    assign ident_s.valid = word_valid_ff;
    assign ident_s.data = word_data_ff;
    assign word_taken = word_valid_ff && ident_s.ready;
    // The output register takes the buffer head only when it is empty or being read.
    assign out_free = !data_valid || data_rd;

    // The buffer absorbs host stalls; the core stops feeding it when it is full.
    word_buffer2 #(.WIDTH(16)) u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_s(ident_s),
        .out_valid(data_valid_w),
        .out_data(data_word_w),
        .out_ready(out_free)
    );

    // Last stage of the stream, so the data pins leave a flip-flop.
    // It refills only when empty or read, so the word on the pins is the one the host takes.
    // A plain copy of the buffer head would lag the pops and repeat or skip words.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_word <= 16'h0000;
            data_valid <= 1'b0;
        end else if (out_free) begin
            data_valid <= data_valid_w;
            if (data_valid_w) begin
                data_word <= data_word_w;
            end
        end
    end

    // Device register; only the select bit is kept, other bits read zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            device_select_ff <= 8'h00;
        end else if (dev_wr) begin
            device_select_ff <= {3'b000, dev_wdata[DEV_BIT], 4'b0000};
        end
    end

    // Command sequencing and status.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= S_IDLE;
            status_ff <= STATUS_RESET;
            error_ff <= 8'h00;
            sector_count_ff <= 8'h00;
            prep_cnt_ff <= 3'd0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    if (cmd_wr) begin
                        error_ff <= 8'h00;
                        if (cmd_wdata == OP_IDENTIFY) begin
                            // Other task-file fields are ignored here.
                            status_ff <= STATUS_RESET | (8'h01 << ST_BSY);
                            prep_cnt_ff <= 3'd0;
                            state_ff <= S_PREP;
                        end else if (cmd_wdata == OP_POWER) begin
                            sector_count_ff <= POWER_ACTIVE;
                            status_ff <= STATUS_RESET;
                        end else if (op_supported(cmd_wdata)) begin
                            status_ff <= STATUS_RESET;
                        end else begin
                            error_ff <= 8'h01 << ERR_ABORT;
                            status_ff <= STATUS_RESET | (8'h01 << ST_ERR);
                        end
                    end
                end
                S_PREP: begin
                    prep_cnt_ff <= 3'(prep_cnt_ff + 1'b1);
                    if (prep_cnt_ff == 3'(PREP_CYCLES - 1)) begin
                        status_ff <= STATUS_RESET | (8'h01 << ST_DRQ);
                        state_ff <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (read_cnt_ff == 9'(IDENT_WORDS - 1) && data_rd && data_valid) begin
                        status_ff <= STATUS_RESET;
                        state_ff <= S_DRAIN;
                    end
                end
                S_DRAIN: begin
                    state_ff <= S_IDLE;
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Identify word producer feeding the buffer in index order.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word_idx_ff <= 9'd0;
            word_valid_ff <= 1'b0;
            word_data_ff <= 16'h0000;
        end else if (state_ff == S_PREP) begin
            word_idx_ff <= 9'd0;
            word_valid_ff <= 1'b0;
        end else if (state_ff == S_XFER && word_idx_ff < 9'(IDENT_WORDS)) begin
            if (!word_valid_ff || word_taken) begin
                // Words 60 and 61 carry the sector total low half first.
                word_data_ff <= ident_word(word_idx_ff[7:0], TOTAL_SECTORS);
                word_valid_ff <= 1'b1;
                word_idx_ff <= 9'(word_idx_ff + 1'b1);
            end
        end else if (word_taken) begin
            word_valid_ff <= 1'b0;
        end
    end

    // Count host reads of the data register.
    always_ff @(posedge clk_sys) begin
        if (rst || state_ff == S_PREP) begin
            read_cnt_ff <= 9'd0;
        end else if (data_rd && data_valid) begin
            read_cnt_ff <= 9'(read_cnt_ff + 1'b1);
        end
    end

    // Interrupt: raised with data request or on any other command taken in idle, when enabled; a status read clears it, but a raise in that cycle wins.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            intrq_ff <= 1'b0;
        end else if (state_ff == S_PREP && prep_cnt_ff == 3'(PREP_CYCLES - 1) && !nien) begin
            intrq_ff <= 1'b1;
        end else if (state_ff == S_IDLE && cmd_wr && cmd_wdata != OP_IDENTIFY && !nien) begin
            intrq_ff <= 1'b1;
        end else if (status_rd) begin
            intrq_ff <= 1'b0;
        end
    end

    // Write path parity, one byte a cycle so the stream never waits.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_lfsr_ff <= 8'h00;
            wr_byte_cnt_ff <= '0;
            parity_ff <= 8'h00;
            parity_valid_ff <= 1'b0;
        end else begin
            parity_valid_ff <= 1'b0;
            if (fl_wr_valid) begin
                wr_byte_cnt_ff <= BYTE_W'(wr_byte_cnt_ff + 1'b1);
                if (wr_byte_cnt_ff == BYTE_W'(ECC_BLOCK_BYTES - 1)) begin
                    parity_ff <= lfsr_step(wr_lfsr_ff, fl_wr_byte);
                    parity_valid_ff <= 1'b1;
                    wr_lfsr_ff <= 8'h00;
                end else begin
                    wr_lfsr_ff <= lfsr_step(wr_lfsr_ff, fl_wr_byte);
                end
            end
        end
    end

    // Read path syndrome over each 512-byte block.
    assign rd_block_end = fl_rd_valid && (rd_byte_cnt_ff == BYTE_W'(ECC_BLOCK_BYTES - 1));
    assign syndrome = lfsr_step(rd_lfsr_ff, fl_rd_byte) ^ fl_rd_parity;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_lfsr_ff <= 8'h00;
            rd_byte_cnt_ff <= '0;
            ecc_corr_ff <= 1'b0;
        end else begin
            ecc_corr_ff <= 1'b0;
            if (fl_rd_valid) begin
                rd_byte_cnt_ff <= BYTE_W'(rd_byte_cnt_ff + 1'b1);
                rd_lfsr_ff <= rd_block_end ? 8'h00 : lfsr_step(rd_lfsr_ff, fl_rd_byte);
            end
            // Up to eight flipped bits per block are fixable by the decoder.
            if (rd_block_end && syndrome != 8'h00 && fl_err_bits <= 4'(ECC_MAX_BITS)) begin
                ecc_corr_ff <= 1'b1;
            end
        end
    end

    // Bad block retirement; a block past the correction limit moves to a spare.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bad_ff <= '0;
            bad_cnt_ff <= '0;
            spare_ff <= BW'(NUM_BLOCKS - 1);
            reloc_req_ff <= 1'b0;
            reloc_src_ff <= '0;
            reloc_dst_ff <= '0;
        end else begin
            reloc_req_ff <= 1'b0;
            // Spares run out at the budgeted fraction; beyond that nothing moves.
            if (rd_block_end && fl_err_bits > 4'(ECC_MAX_BITS) && !bad_ff[fl_rd_block]
                && bad_cnt_ff < (BW+1)'(BAD_MAX)) begin
                bad_ff[fl_rd_block] <= 1'b1;
                bad_cnt_ff <= (BW+1)'(bad_cnt_ff + 1'b1);
                reloc_src_ff <= fl_rd_block;
                reloc_dst_ff <= spare_ff;
                reloc_req_ff <= 1'b1;
                spare_ff <= BW'(spare_ff - 1'b1);
            end
        end
    end

    // Placement: each sector write takes a fresh slot, pages then blocks.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phys_block_ff <= '0;
            phys_page_ff <= '0;
            sect_in_page_ff <= 3'd0;
        end else if (sector_wr_req) begin
            sect_in_page_ff <= 3'(sect_in_page_ff + 1'b1);
            if (sect_in_page_ff == 3'(SECT_PER_PAGE - 1)) begin
                if (phys_page_ff == PW'(PAGES_PER_BLOCK - 1)) begin
                    phys_page_ff <= '0;
                    phys_block_ff <= next_good(phys_block_ff, bad_ff);
                end else begin
                    phys_page_ff <= PW'(phys_page_ff + 1'b1);
                end
            end
        end
    end
endmodule

// file: ata_core_pkg.sv
// Shared constants, status layout and the identify table for the command core.
package ata_core_pkg;
    localparam logic [7:0] OP_IDENTIFY = 8'hec;
    localparam logic [7:0] OP_POWER = 8'he5;
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int DEV_BIT = 4;
    localparam int ERR_ABORT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [7:0] POWER_ACTIVE = 8'hff;
    localparam int IDENT_WORDS = 256;
    localparam int PREP_CYCLES = 4;
    localparam int ECC_BLOCK_BYTES = 512;
    localparam int ECC_MAX_BITS = 8;
    localparam int PAGE_BYTES = 4096;
    localparam int BAD_PERMILLE = 67;
    localparam logic [7:0] ECC_POLY = 8'h1d;

    // Opcodes that the command set accepts.
    function automatic logic op_supported(input logic [7:0] op);
        case (op)
            8'he5, 8'hec, 8'he3, 8'he1, 8'hb0, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41,
            8'hc8, 8'hc9, 8'hef, 8'hc6, 8'he6, 8'he7, 8'he2, 8'he0, 8'hc5, 8'h30,
            8'h31, 8'hca, 8'hcb, 8'h90, 8'h91, 8'h10, 8'hf6, 8'hf3, 8'hf4, 8'hf5,
            8'hf1, 8'hf2, 8'he4, 8'he8: op_supported = 1'b1;
            default: op_supported = (op[7:4] == 4'h7);
        endcase
    endfunction

    // Identify table; every word not listed is reserved and reads zero.
    function automatic logic [15:0] ident_word(input logic [7:0] idx, input logic [31:0] secs);
        case (idx)
            8'd0: ident_word = 16'h0040;
            8'd2: ident_word = 16'hc837;
            8'd47: ident_word = 16'h8001;
            8'd49: ident_word = 16'h2f00;
            8'd50: ident_word = 16'h4000;
            8'd53: ident_word = 16'h0007;
            8'd59: ident_word = 16'h0101;
            8'd60: ident_word = secs[15:0];
            8'd61: ident_word = secs[31:16];
            8'd63: ident_word = 16'h0007;
            8'd64: ident_word = 16'h0003;
            8'd65, 8'd66, 8'd67, 8'd68: ident_word = 16'h0078;
            8'd80: ident_word = 16'h00f0;
            8'd82: ident_word = 16'h304b;
            8'd83: ident_word = 16'h5000;
            8'd84: ident_word = 16'h4000;
            8'd86: ident_word = 16'h1000;
            8'd88: ident_word = 16'h7f3f;
            default: ident_word = 16'h0000;
        endcase
    endfunction
endpackage

// file: word_stream_if.sv
// Valid/ready word stream between the command core and its output buffer.
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: word_buffer2.sv
// Two-entry buffer so that a stall by the reader loses no word.
`timescale 1ns/1ps
module word_buffer2 #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    word_stream_if.snk in_s,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem_ff [2];
    logic rd_ptr_ff;
    logic wr_ptr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    initial begin
        if (WIDTH < 1) $error("word_buffer2 needs a positive width.");
    end

    // Ready is honest: it drops as soon as both entries hold data.
    assign in_s.ready = (count_ff != 2'd2);
    assign push = in_s.valid && in_s.ready;
    assign pop = (count_ff != 2'd0) && out_ready;
    assign out_valid = (count_ff != 2'd0);
    assign out_data = mem_ff[rd_ptr_ff];

    // Storage writes.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_s.data;
        end
    end

    // Pointers and fill level.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff <= 2'd0;
        end else begin
            if (push) wr_ptr_ff <= ~wr_ptr_ff;
            if (pop) rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= 2'(count_ff + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule

// file: ata_device_command_core_monitor.sv
// Concurrent checks on the ports of the command core.
`timescale 1ns/1ps
module ata_cmd_checker
    import ata_core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic dev_wr,
    input wire logic [7:0] dev_wdata,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic status_rd,
    input wire logic nien,
    input wire logic [7:0] status_ff,
    input wire logic [7:0] device_select_ff,
    input wire logic [7:0] error_ff,
    input wire logic [7:0] sector_count_ff,
    input wire logic intrq_ff,
    input wire logic fl_wr_valid,
    input wire logic parity_valid_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic idle;
    logic [8:0] wr_cnt_ff;
    // A command is only taken with neither busy nor data request up.
    assign idle = !status_ff[ST_BSY] && !status_ff[ST_DRQ];
    // Counts write bytes so the parity pulse can be tied to the last one of a block.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_cnt_ff <= 9'h000;
        end else if (fl_wr_valid) begin
            wr_cnt_ff <= wr_cnt_ff + 9'h001;
        end
    end
    sequence s_prep;
        status_ff == 8'hc0 [*4];
    endsequence
    sequence s_drq;
        status_ff == 8'h48;
    endsequence
    property p_busy;
        idle && cmd_wr && cmd_wdata == OP_IDENTIFY |=> status_ff == 8'hc0;
    endproperty
    property p_prep;
        $rose(status_ff[ST_BSY]) |-> s_prep ##1 s_drq;
    endproperty
    property p_irq;
        $rose(status_ff[ST_DRQ]) && !nien |-> intrq_ff;
    endproperty
    property p_irq_clr;
        status_rd && !cmd_wr && !status_ff[ST_BSY] |=> !intrq_ff;
    endproperty
    property p_done;
        $fell(status_ff[ST_DRQ]) |-> status_ff == 8'h40;
    endproperty
    property p_unknown;
        idle && cmd_wr && cmd_wdata == 8'h00 |=> status_ff == 8'h41 && error_ff == 8'h04;
    endproperty
    property p_good;
        idle && cmd_wr && cmd_wdata inside {8'h20, 8'h21, 8'h30, 8'h31, 8'hc8, 8'hc9}
            |=> status_ff == 8'h40;
    endproperty
    property p_power;
        idle && cmd_wr && cmd_wdata == OP_POWER |=> sector_count_ff == POWER_ACTIVE;
    endproperty
    property p_dev;
        dev_wr |=> device_select_ff == {3'h0, $past(dev_wdata[DEV_BIT]), 4'h0};
    endproperty
    property p_parity;
        fl_wr_valid && wr_cnt_ff == 9'h1ff |-> ##[1:2] parity_valid_ff;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not raised by identify");
    a_prep: assert property (p_prep) else $error("identify preparation wrong");
    a_irq: assert property (p_irq) else $error("interrupt missing at data request");
    a_irq_clr: assert property (p_irq_clr) else $error("status read kept interrupt");
    a_done: assert property (p_done) else $error("status wrong after identify");
    a_unknown: assert property (p_unknown) else $error("unknown opcode not aborted");
    a_good: assert property (p_good) else $error("supported opcode refused");
    a_power: assert property (p_power) else $error("power mode answer wrong");
    a_dev: assert property (p_dev) else $error("device select not echoed");
    a_parity: assert property (p_parity) else $error("parity pulse missing");
endmodule

bind ata_device_command_core ata_cmd_checker u_ata_cmd_checker (.clk_sys, .rst, .dev_wr,
    .dev_wdata, .cmd_wr, .cmd_wdata, .status_rd, .nien, .status_ff, .device_select_ff,
    .error_ff, .sector_count_ff, .intrq_ff, .fl_wr_valid, .parity_valid_ff);

// file: ata_host_model.sv
// Host-side model that drains identify words from the data port.
`timescale 1ns/1ps
module ata_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic [15:0] data_word,
    input wire logic data_valid,
    output logic data_rd
);
    logic [15:0] words [0:255];
    int n_got;
    logic ph_ff;
    // Each taken word is stored in arrival order; a slow host stalls the buffer.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            n_got <= 0;
            ph_ff <= 1'b0;
        end else begin
            ph_ff <= ~ph_ff;
            if (data_rd && data_valid) begin
                words[n_got[7:0]] <= data_word;
                n_got <= n_got + 1;
            end
        end
    end
    // Reads are successive data register accesses, every other cycle when slow.
    assign data_rd = data_valid && (!slow || ph_ff);
endmodule

// file: ata_device_command_core_tb.sv
// Self-checking bench for the command core.
`timescale 1ns/1ps
module ata_device_command_core_tb;
    import ata_core_pkg::*;
    localparam logic [31:0] SECS = 32'h1234_5678;
    localparam int LIMIT = 20000;
    logic clk_sys, rst, dev_wr, cmd_wr, status_rd, nien, data_rd, slow, data_valid, intrq_ff;
    logic [7:0] dev_wdata, cmd_wdata, status_ff, device_select_ff, error_ff, sector_count_ff;
    logic [15:0] data_word;
    logic fl_wr_valid, fl_rd_valid, sector_wr_req, parity_valid_ff, ecc_corr_ff, reloc_req_ff;
    logic [7:0] fl_wr_byte, fl_rd_byte, fl_rd_parity, parity_ff;
    logic [3:0] fl_err_bits;
    logic [5:0] fl_rd_block, reloc_src_ff, reloc_dst_ff, phys_block_ff, phys_page_ff;
    int n_fail, checked, cyc;

    ata_device_command_core #(.TOTAL_SECTORS(SECS)) u_ata_device_command_core (.clk_sys,
        .rst, .dev_wr, .dev_wdata, .cmd_wr, .cmd_wdata, .status_rd, .nien, .data_rd,
        .data_word, .data_valid, .status_ff, .device_select_ff, .error_ff, .sector_count_ff,
        .intrq_ff, .fl_wr_valid, .fl_wr_byte, .fl_rd_valid, .fl_rd_byte, .fl_rd_parity,
        .fl_err_bits, .fl_rd_block, .sector_wr_req, .parity_ff, .parity_valid_ff, .ecc_corr_ff,
        .reloc_src_ff, .reloc_dst_ff, .reloc_req_ff, .phys_block_ff, .phys_page_ff);
    ata_host_model u_ata_host_model (.clk_sys, .rst, .slow, .data_word, .data_valid,
        .data_rd);

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Inputs always change one nanosecond after the rising edge.
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic cmd(input logic [7:0] op);
        cmd_wr = 1'b1;
        cmd_wdata = op;
        tick();
        cmd_wr = 1'b0;
    endtask

    task automatic read_status();
        status_rd = 1'b1;
        tick();
        status_rd = 1'b0;
        chk(intrq_ff, 1'b0);
    endtask

    task automatic t_identify(input logic irq_off, input logic slow_v);
        int base;
        base = u_ata_host_model.n_got;
        nien = irq_off;
        slow = slow_v;
        dev_wr = 1'b1;
        dev_wdata = 8'hff;
        tick();
        dev_wr = 1'b0;
        chk(device_select_ff, 8'h10);
        cmd(OP_IDENTIFY);
        chk(status_ff, 8'hc0);
        tick();
        // A command sent while busy must be dropped without disturbing the transfer.
        cmd(OP_POWER);
        tick();
        chk(status_ff, 8'hc0);
        chk(sector_count_ff, 8'h00);
        tick();
        chk(status_ff, 8'h48);
        chk(intrq_ff, !irq_off);
        for (int i = 0; i < 2000 && u_ata_host_model.n_got != base + 256; i++) tick();
        chk(u_ata_host_model.n_got - base, 256);
        tick(2);
        chk(status_ff, 8'h40);
        chk(device_select_ff, 8'h10);
        chk(u_ata_host_model.words[0], 16'h0040);
        chk(u_ata_host_model.words[2], 16'hc837);
        chk(u_ata_host_model.words[49], 16'h2f00);
        chk(u_ata_host_model.words[48], 16'h0000);
        chk(u_ata_host_model.words[60], SECS[15:0]);
        chk(u_ata_host_model.words[61], SECS[31:16]);
        read_status();
    endtask

    task automatic t_cmds();
        logic [7:0] ops [8] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'hc8, 8'hc9, 8'hca, 8'hcb};
        nien = 1'b0;
        foreach (ops[i]) begin
            cmd(ops[i]);
            chk(status_ff, 8'h40);
            tick();
        end
        read_status();
        cmd(8'h00);
        chk({status_ff, error_ff, 7'h00, intrq_ff}, 24'h41_04_01);
        tick();
        read_status();
        cmd(OP_POWER);
        chk({sector_count_ff, status_ff}, 16'hff_40);
        dev_wr = 1'b1;
        dev_wdata = 8'hef;
        tick();
        dev_wr = 1'b0;
        chk(device_select_ff, 8'h00);
    endtask

    // One 512-byte block on the write or the read stream; the caller looks at the pulses
    // before the next edge and then lets that edge pass.
    task automatic stream(input logic rd, input logic [3:0] eb);
        fl_err_bits = eb;
        for (int i = 0; i < 512; i++) begin
            fl_wr_valid = !rd;
            fl_rd_valid = rd;
            fl_wr_byte = i[7:0];
            fl_rd_byte = i[7:0];
            tick();
        end
        fl_wr_valid = 1'b0;
        fl_rd_valid = 1'b0;
    endtask

    task automatic place();
        sector_wr_req = 1'b1;
        tick();
        sector_wr_req = 1'b0;
        tick();
    endtask

    task automatic t_flash();
        logic [11:0] where;
        stream(1'b0, 4'h0);
        chk(parity_valid_ff, 1'b1);
        tick();
        fl_rd_block = 6'h05;
        // Inverted stored parity guarantees a nonzero syndrome on the same bytes.
        fl_rd_parity = ~parity_ff;
        stream(1'b1, 4'h8);
        chk({ecc_corr_ff, reloc_req_ff}, 2'b10);
        tick();
        stream(1'b1, 4'h9);
        chk({ecc_corr_ff, reloc_req_ff}, 2'b01);
        chk({reloc_src_ff, reloc_dst_ff}, {6'h05, 6'h3f});
        tick();
        place();
        where = {phys_block_ff, phys_page_ff};
        // A full page of sector slots later the same sector must sit on another page.
        repeat (PAGE_BYTES / ECC_BLOCK_BYTES) place();
        chk(where != {phys_block_ff, phys_page_ff}, 1'b1);
    endtask

    task automatic final_report();
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {rst, dev_wr, cmd_wr, status_rd, nien, slow} = 6'b100000;
        {dev_wdata, cmd_wdata, fl_wr_byte, fl_rd_byte, fl_rd_parity} = 40'h0;
        {fl_wr_valid, fl_rd_valid, sector_wr_req, fl_err_bits, fl_rd_block} = 13'h0;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        tick(2);
        rst = 1'b0;
        chk({status_ff, device_select_ff, error_ff, intrq_ff}, {STATUS_RESET, 17'h00000});
        t_identify(1'b0, 1'b0);
        t_identify(1'b1, 1'b1);
        t_cmds();
        t_flash();
        final_report();
    end
endmodule
